// ### hdl/dual_timer.sv
// What this block does
// - Core timer underflow leaves the block as an export pulse.
// - Counting down, toggle latch flips only on underflow 0000 to FFFF.
// - Aux down with clear: capture latches, clears, next clock wraps to FFFF.
// - Reload mode, core counting up: overflow reloads core from capture value.
// - Down-count correction leaves two's complement of interval in capture value.
// - Source select set: capture on position-timer input edges per edge field.
// - Source clear, rising: reads of middle position timer trigger capture; reads of the others only with read source set.
// - Basic clock: prescaler 01 div2, 00 div4, 11 div8, 10 div16.
// - Block prescaler resets to 00, divide by four.
// - Timer modes: count clock is module clock over F times two-power select.
// - Counter mode: count clock from external input pin transitions.
// - Inputs sampled on basic clock; transition when two samples differ.
// - Timer flag set on overflow up or underflow down.
// - Matching capture-pin transition sets capture request flag.
// - Separate identical request flags for aux, core and capture.
// - Source clear: edge field selects none, rising, falling or any edge.
// - Clear-on-capture clears timer after aux value is latched.
// - Reload does not raise the capture request.
// - Output enable drives toggle latch onto output pin.
`timescale 1ns/1ps
`include "dual_timer_defs.svh"

module dual_timer
  import dual_timer_pkg::*;
#(
  parameter int TW = `TMR_W
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Configuration
  input  wire dual_timer_pkg::timer_cfg_t aux_cfg_i,
  input  wire dual_timer_pkg::timer_cfg_t core_cfg_i,
  input  wire dual_timer_pkg::block_cfg_t blk_cfg_i,
  // External inputs and position reads
  input  wire dual_timer_pkg::ext_in_t ext_i,
  input  wire logic                    read_pos_a_i,
  input  wire logic                    read_pos_b_i,
  input  wire logic                    read_pos_c_i,
  // Software flag clears
  input  wire dual_timer_pkg::irq_t    flag_clear_i,
  // Status and outputs
  output logic [TW-1:0]                auxiliary_counter_o,
  output logic [TW-1:0]                core_counter_o,
  output logic [TW-1:0]                capture_reload_value_o,
  output logic                         core_toggle_latch_o,
  output logic                         core_underflow_export_o,
  output logic                         toggle_output_pin_o,
  output dual_timer_pkg::irq_t         flags_o
);
  import dual_timer_pkg::*;

  // Wrap and reload compares need at least two bits
  if (TW < 2)
  begin
    $error("dual_timer: TW too small");
  end

  typedef struct packed {
    logic [3:0]        bpre;
    logic [`PRE_W-1:0] tick_cnt;
    logic [TW-1:0]     aux;
    logic [TW-1:0]     core;
    logic [TW-1:0]     capture_reload_value;
    logic              tl;
    logic              uf;
    irq_t              flags;
  } dt_state_t;

  dt_state_t state_reg;
  dt_state_t state_next;

  // Prescale factor minus one per select code
  function automatic logic [3:0] bps_mask(input logic [1:0] sel);
    case (sel)
      `BPS_DIV2: bps_mask = 4'h1;
      `BPS_DIV4: bps_mask = 4'h3;
      `BPS_DIV8: bps_mask = 4'h7;
      default:   bps_mask = 4'hF;
    endcase
  endfunction

  // Timer tick enable from mode, gate and pins
  function automatic logic tick_of(input timer_cfg_t c, input logic base,
                                   input logic [`PRE_W-1:0] cnt, input logic lvl,
                                   input logic edg);
    logic [`PRE_W-1:0] m;
    m = (`PRE_W'(1) << c.input_prescale) - `PRE_W'(1);
    case (c.mode)
      `MODE_TIMER:     tick_of = base && ((cnt & m) == '0);
      `MODE_COUNTER:   tick_of = edg;
      `MODE_GATE_LOW:  tick_of = base && ((cnt & m) == '0) && !lvl;
      `MODE_GATE_HIGH: tick_of = base && ((cnt & m) == '0) && lvl;
      default:         tick_of = 1'b0;
    endcase
  endfunction

  logic       basic_tick;
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  logic       pin_edge;
  logic       pos_edge;
  logic       read_trig;
  logic       cap_trig;
  logic       aux_tick;
  logic       core_tick;
  logic       core_ovf;
  logic       core_unf;
  logic       aux_wrap;

  // Basic clock strobe from module clock
  assign basic_tick = (state_reg.bpre & bps_mask(blk_cfg_i.block_prescale_select)) == 4'h0;

  edge_sampler #(.WIDTH(5)) u_samp (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (basic_tick),
    .level_i   (ext_i),
    .level_o   (lvl),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // Bit order follows ext_in_t: 4 capture pin, 3 pos count, 2 pos dir, 1 aux, 0 core
  always_comb
  begin
    pin_edge = 1'b0;
    pos_edge = 1'b0;
    case (blk_cfg_i.capture_edge_select)
      `EDGE_RISE:
      begin
        pin_edge = rise[4];
        pos_edge = rise[3] | fall[3];
      end
      `EDGE_FALL:
      begin
        pin_edge = fall[4];
        pos_edge = rise[2] | fall[2];
      end
      `EDGE_ANY:
      begin
        pin_edge = rise[4] | fall[4];
        pos_edge = rise[3] | fall[3] | rise[2] | fall[2];
      end
      default:
      begin
        pin_edge = 1'b0;
        pos_edge = 1'b0;
      end
    endcase
  end

  // Reads act only with rising selected and source clear
  assign read_trig = (blk_cfg_i.capture_edge_select == `EDGE_RISE) &&
                     (read_pos_b_i || (blk_cfg_i.read_capture_source &&
                      (read_pos_a_i || read_pos_c_i)));
  assign cap_trig = blk_cfg_i.capture_source_select ? pos_edge : (pin_edge || read_trig);

  assign aux_tick  = aux_cfg_i.run && tick_of(aux_cfg_i, basic_tick, state_reg.tick_cnt,
                     lvl[1], rise[1] | fall[1]);
  assign core_tick = core_cfg_i.run && tick_of(core_cfg_i, basic_tick, state_reg.tick_cnt,
                     lvl[0], rise[0] | fall[0]);
  assign core_ovf  = core_tick && !core_cfg_i.count_down && (state_reg.core == '1);
  assign core_unf  = core_tick && core_cfg_i.count_down && (state_reg.core == '0);
  assign aux_wrap  = aux_tick && (aux_cfg_i.count_down ? (state_reg.aux == '0)
                                                       : (state_reg.aux == '1));

  always_comb
  begin
    state_next = state_reg;
    state_next.bpre = state_reg.bpre + 4'h1;
    state_next.uf   = core_unf;
    if (basic_tick)
      state_next.tick_cnt = state_reg.tick_cnt + `PRE_W'(1);
    if (aux_tick)
      state_next.aux = aux_cfg_i.count_down ? state_reg.aux - TW'(1)
                                            : state_reg.aux + TW'(1);
    if (core_tick)
      state_next.core = core_cfg_i.count_down ? state_reg.core - TW'(1)
                                              : state_reg.core + TW'(1);
    if ((core_ovf || core_unf) && core_cfg_i.reload_enable)
      state_next.core = state_reg.capture_reload_value;
    if (core_ovf || core_unf)
      state_next.tl = ~state_reg.tl;
    for (int i = 0; i < 3; i++)
      if (flag_clear_i[i])
        state_next.flags[i] = 1'b0;
    // Set after clear so a same-cycle event wins
    if (cap_trig)
    begin
      if (blk_cfg_i.capture_enable)
        state_next.capture_reload_value = state_reg.aux;
      if (aux_cfg_i.clear_on_capture)
        state_next.aux = '0;
      if (core_cfg_i.clear_on_capture)
        state_next.core = '0;
      if (!blk_cfg_i.capture_source_select)
        state_next.flags.capture_flag = 1'b1;
    end
    if (aux_wrap)
      state_next.flags.aux_flag = 1'b1;
    if (core_ovf || core_unf)
      state_next.flags.core_flag = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign auxiliary_counter_o     = state_reg.aux;
  assign core_counter_o          = state_reg.core;
  assign capture_reload_value_o  = state_reg.capture_reload_value;
  assign core_toggle_latch_o     = state_reg.tl;
  assign core_underflow_export_o = state_reg.uf;
  assign toggle_output_pin_o     = blk_cfg_i.toggle_output_enable & state_reg.tl;
  assign flags_o                 = state_reg.flags;

  // Assertions
  sequence core_under_s;
    core_unf;
  endsequence

  AST_EXPORT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    core_under_s |=> core_underflow_export_o)
    else $error("underflow not exported");
  AST_TOGGLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (core_ovf || core_unf) |=> (core_toggle_latch_o != $past(core_toggle_latch_o)))
    else $error("toggle latch did not flip");
  AST_STILL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(core_ovf || core_unf) |=> $stable(core_toggle_latch_o))
    else $error("toggle latch flipped without wrap");
  AST_RELOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (core_ovf && core_cfg_i.reload_enable && !cap_trig) |=>
      (core_counter_o == $past(capture_reload_value_o)))
    else $error("reload missed");
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cap_trig && blk_cfg_i.capture_enable) |=>
      (capture_reload_value_o == $past(auxiliary_counter_o)))
    else $error("capture value wrong");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cap_trig && aux_cfg_i.clear_on_capture) |=> (auxiliary_counter_o == '0))
    else $error("aux not cleared");
  AST_CORE_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (core_ovf || core_unf) |=> flags_o.core_flag)
    else $error("core flag not set");
  AST_AUX_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    aux_wrap |=> flags_o.aux_flag)
    else $error("aux flag not set");
  AST_CAP_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cap_trig && !blk_cfg_i.capture_source_select) |=> flags_o.capture_flag)
    else $error("capture flag not set");
  AST_NO_RELOAD_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!cap_trig && flags_o.capture_flag == 1'b0) |=> !flags_o.capture_flag)
    else $error("capture flag rose without trigger");
  AST_BASIC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (blk_cfg_i.block_prescale_select == `BPS_DIV2 && basic_tick) ##1
    (blk_cfg_i.block_prescale_select == `BPS_DIV2) |->
      (!basic_tick ##1 (blk_cfg_i.block_prescale_select != `BPS_DIV2 || basic_tick)))
    else $error("basic clock period wrong");
  AST_PIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !blk_cfg_i.toggle_output_enable |-> !toggle_output_pin_o)
    else $error("pin driven while disabled");

endmodule

// ### hdl/edge_sampler.sv
`timescale 1ns/1ps
`include "dual_timer_defs.svh"

module edge_sampler #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Sample strobe and inputs
  input  wire logic             sample_i,
  input  wire logic [WIDTH-1:0] level_i,
  // Results
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);
  if (WIDTH < 1)
  begin
    $error("edge_sampler: WIDTH must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cur;
    logic             primed;
  } samp_state_t;

  samp_state_t state_reg;
  samp_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (sample_i)
    begin
      state_next.primed = 1'b1;
      state_next.cur    = level_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Edge only on strobe: two consecutive samples differ
  // First sample after reset only primes, so an idle-high pin gives no false edge
  assign level_o = state_reg.cur;
  assign rise_o  = (sample_i && state_reg.primed) ? (level_i & ~state_reg.cur) : '0;
  assign fall_o  = (sample_i && state_reg.primed) ? (~level_i & state_reg.cur) : '0;

endmodule

// ### pkg/dual_timer_defs.svh
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

`define TMR_W            16
`define BPS_DIV2         2'b01
`define BPS_DIV4         2'b00
`define BPS_DIV8         2'b11
`define BPS_DIV16        2'b10
`define BPS_RESET        2'b00
`define EDGE_NONE        2'b00
`define EDGE_RISE        2'b01
`define EDGE_FALL        2'b10
`define EDGE_ANY         2'b11
`define MODE_TIMER       3'b000
`define MODE_COUNTER     3'b001
`define MODE_GATE_LOW    3'b010
`define MODE_GATE_HIGH   3'b011
`define PRE_W            13

`endif

// ### pkg/dual_timer_pkg.sv
package dual_timer_pkg;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] input_prescale;
    logic       run;
    logic       count_down;
    logic       clear_on_capture;
    logic       reload_enable;
  } timer_cfg_t;

  typedef struct packed {
    logic       capture_enable;
    logic       capture_source_select;
    logic [1:0] capture_edge_select;
    logic       read_capture_source;
    logic       toggle_output_enable;
    logic [1:0] block_prescale_select;
  } block_cfg_t;

  typedef struct packed {
    logic capture_input_pin;
    logic position_count_input;
    logic position_direction_input;
    logic aux_count_input;
    logic core_count_input;
  } ext_in_t;

  typedef struct packed {
    logic aux_flag;
    logic core_flag;
    logic capture_flag;
  } irq_t;

endpackage

// ### tb/sensor_model.sv
`timescale 1ns/1ps

module sensor_model
  import dual_timer_pkg::*;
#(
  parameter int HOLD = 4
) (
  // Clock
  input  wire logic                    clk_i,
  // Commanded and driven levels
  input  wire dual_timer_pkg::ext_in_t want_i,
  output dual_timer_pkg::ext_in_t      ext_o
);
  ext_in_t pend_reg;
  int      held_reg;

  initial
  begin
    ext_o = '0;
    pend_reg = '0;
    held_reg = 0;
  end

  // Latched on the rising edge so the falling-edge update never races the bench
  always @(posedge clk_i)
    pend_reg <= want_i;

  // Real sensors cannot chatter faster than the sampling allows
  always @(negedge clk_i)
  begin
    if (pend_reg !== ext_o && held_reg >= HOLD)
    begin
      ext_o <= pend_reg;
      held_reg <= 0;
    end
    else if (held_reg < HOLD)
    begin
      held_reg <= held_reg + 1;
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`include "dual_timer_defs.svh"

module tb;
  import dual_timer_pkg::*;

  typedef struct packed {
    logic       src;
    logic [1:0] edg;
    logic       rsrc;
    logic       p0;
    logic       p1;
    logic [1:0] pos;
    logic [2:0] rd;
    logic       ef;
    logic       ec;
  } row_t;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  timer_cfg_t  aux_cfg = '0;
  timer_cfg_t  core_cfg = '0;
  block_cfg_t  blk = '0;
  ext_in_t     want = '0;
  ext_in_t     ext;
  irq_t        fclr = '0;
  irq_t        flags;
  logic [2:0]  rd = 3'h0;
  logic [15:0] aux, core, cap, c0;
  logic        latch, uflow, pin;
  int          errors = 0;
  int          checked = 0;
  int          i;
  int          j;
  logic [1:0]  bps [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
  int          pre [5] = '{0, 0, 0, 0, 1};
  int          span [5] = '{32, 16, 8, 4, 16};
  row_t        rows [14] = '{
    '{0,0,0,0,1,0,0,0,0}, '{0,1,0,0,1,0,0,1,1}, '{0,1,0,1,0,0,0,0,0},
    '{0,2,0,1,0,0,0,1,1}, '{0,2,0,0,1,0,0,0,0}, '{0,3,0,0,1,0,0,1,1},
    '{0,3,0,1,0,0,0,1,1}, '{0,1,0,0,0,0,4,0,0}, '{0,1,0,0,0,0,2,1,1},
    '{0,1,1,0,0,0,1,1,1}, '{1,1,0,0,0,2,0,0,1}, '{1,2,0,0,0,2,0,0,0},
    '{1,2,0,0,0,1,0,0,1}, '{1,3,0,0,0,1,0,0,1}};

  always #10 clk_i = ~clk_i;

  dual_timer uut (
    .clk_i                  (clk_i),
    .sys_rst_i              (sys_rst_i),
    .aux_cfg_i              (aux_cfg),
    .core_cfg_i             (core_cfg),
    .blk_cfg_i              (blk),
    .ext_i                  (ext),
    .read_pos_a_i           (rd[2]),
    .read_pos_b_i           (rd[1]),
    .read_pos_c_i           (rd[0]),
    .flag_clear_i           (fclr),
    .auxiliary_counter_o    (aux),
    .core_counter_o         (core),
    .capture_reload_value_o (cap),
    .core_toggle_latch_o    (latch),
    .core_underflow_export_o(uflow),
    .toggle_output_pin_o    (pin),
    .flags_o                (flags)
  );

  sensor_model sens (
    .clk_i (clk_i),
    .want_i(want),
    .ext_o (ext)
  );

  task check(input logic [15:0] seen, input logic [15:0] exp_v);
    checked++;
    if (seen !== exp_v)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp_v);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task clr(input irq_t f);
    fclr = f;
    tick(1);
    fclr = '0;
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run is near 1050 cycles; this is a generous cut-off
  initial
  begin
    repeat (6000) @(posedge clk_i);
    errors++;
    print_verdict;
  end

  initial
  begin
    tick(16);
    check(aux | core | cap, 16'h0000);
    check(16'({latch, uflow, pin, flags}), 16'h0000);
    sys_rst_i = 1'b0;
    blk.block_prescale_select = `BPS_DIV2;
    blk.toggle_output_enable = 1'b1;
    blk.capture_enable = 1'b1;
    tick(2);
    // Core down from zero: single underflow
    core_cfg.count_down = 1'b1;
    core_cfg.run = 1'b1;
    for (i = 0; i < 40 && uflow !== 1'b1; i++) tick(1);
    check(16'(uflow), 16'h0001);
    check(core, 16'hffff);
    check(16'({latch, pin, flags.core_flag}), 16'h0007);
    tick(1);
    check(16'(uflow), 16'h0000);
    tick(9);
    check(16'(latch), 16'h0001);
    core_cfg.run = 1'b0;
    // Capture triggers, one row each
    aux_cfg.run = 1'b1;
    for (j = 0; j < 14; j++)
    begin
      blk.capture_source_select = rows[j].src;
      blk.capture_edge_select = rows[j].edg;
      blk.read_capture_source = rows[j].rsrc;
      want.capture_input_pin = rows[j].p0;
      tick(12);
      clr(irq_t'(3'h1));
      tick(2);
      c0 = cap;
      want.capture_input_pin = rows[j].p1;
      want.position_count_input ^= rows[j].pos[1];
      want.position_direction_input ^= rows[j].pos[0];
      rd = rows[j].rd;
      tick(1);
      rd = 3'h0;
      tick(12);
      check(16'(flags.capture_flag), 16'(rows[j].ef));
      check(16'(cap !== c0), 16'(rows[j].ec));
    end
    // Count rate over 64 cycles for each block prescale setting, plus input prescale 1
    for (j = 0; j < 5; j++)
    begin
      blk.block_prescale_select = bps[j];
      aux_cfg.input_prescale = 3'(pre[j]);
      tick(20);
      c0 = aux;
      tick(64);
      check(16'((aux - c0) >= span[j] - 1 && (aux - c0) <= span[j] + 1), 16'h0001);
    end
    blk.block_prescale_select = 2'h1;
    aux_cfg.input_prescale = 3'h0;
    // Aux down with clear on capture
    aux_cfg.count_down = 1'b1;
    aux_cfg.clear_on_capture = 1'b1;
    blk.capture_source_select = 1'b0;
    blk.capture_edge_select = 2'h1;
    tick(12);
    clr(irq_t'(3'h7));
    want.capture_input_pin = 1'b1;
    for (i = 0; i < 20 && flags.capture_flag !== 1'b1; i++) tick(1);
    check(16'(cap != 16'h0000), 16'h0001);
    for (i = 0; i < 10 && aux !== 16'hffff; i++) tick(1);
    check(aux, 16'hffff);
    check(16'(flags.aux_flag), 16'h0001);
    want.capture_input_pin = 1'b0;
    tick(12);
    clr(irq_t'(3'h1));
    want.capture_input_pin = 1'b1;
    for (i = 0; i < 20 && flags.capture_flag !== 1'b1; i++) tick(1);
    check(16'(cap >= 16'hff00), 16'h0001);
    // Core up with reload from the captured value
    clr(irq_t'(3'h3));
    core_cfg.count_down = 1'b0;
    core_cfg.reload_enable = 1'b1;
    core_cfg.run = 1'b1;
    for (i = 0; i < 40 && flags.core_flag !== 1'b1; i++) tick(1);
    check(16'(core >= 16'hff00), 16'h0001);
    check(16'(flags.capture_flag), 16'h0000);
    check(16'(latch), 16'h0000);
    // Output pin follows the latch only while enabled
    blk.toggle_output_enable = 1'b0;
    for (i = 0; i < 80 && latch !== 1'b1; i++) tick(1);
    check(16'({latch, pin}), 16'h0002);
    blk.toggle_output_enable = 1'b1;
    tick(1);
    check(16'({latch, pin}), 16'h0003);
    // Counter mode: one count per sampled input transition
    aux_cfg.mode = `MODE_COUNTER;
    aux_cfg.count_down = 1'b0;
    aux_cfg.clear_on_capture = 1'b0;
    tick(4);
    c0 = aux;
    for (j = 0; j < 4; j++)
    begin
      want.aux_count_input = ~want.aux_count_input;
      tick(6);
    end
    tick(4);
    check(aux - c0, 16'h0004);
    // Gated modes: count only while the gate level matches
    aux_cfg.mode = `MODE_GATE_HIGH;
    tick(4);
    c0 = aux;
    tick(20);
    check(aux, c0);
    want.aux_count_input = 1'b1;
    tick(6);
    c0 = aux;
    tick(20);
    check(16'(16'(aux - c0) >= 16'd9 && 16'(aux - c0) <= 16'd11), 16'h0001);
    aux_cfg.mode = `MODE_GATE_LOW;
    tick(4);
    c0 = aux;
    tick(20);
    check(aux, c0);
    // Reset in mid-run; the capture pin stays high and must not look like an edge
    sys_rst_i = 1'b1;
    tick(2);
    check(aux | core | cap, 16'h0000);
    check(16'({latch, uflow, pin, flags}), 16'h0000);
    sys_rst_i = 1'b0;
    tick(4);
    check(16'(flags.capture_flag), 16'h0000);
    print_verdict;
  end
endmodule
